/* hdl/irs_top.sv */
// Initial reset, interrupt gating and memories of the 4-bit core
`include "irs_consts.svh"
module irs_top #(
    parameter int TICK_DIV = `IRS_TICK_DIV,
    parameter int FILT_OSC = `IRS_KEY_FILT_OSC
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst_b,
    input  wire logic              i_reset_pin_b,
    input  wire logic              i_low_speed_osc,
    input  wire logic [3:0]        i_key_input_group,
    input  wire irs_pkg::irs_cfg_s i_cfg,
    input  wire irs_pkg::irs_stack_s i_stack,
    input  wire logic              i_prefix_wr,
    input  wire logic              i_instr_done,
    input  wire logic              i_int_flag_wr,
    input  wire logic              i_int_flag_data,
    input  wire logic              i_sleep_decode,
    input  wire logic              i_rom_wr,
    input  wire logic [12:0]       i_rom_addr,
    input  wire logic [12:0]       i_rom_wdata,
    input  wire logic              i_ram_wr,
    input  wire logic              i_ram_wide,
    input  wire logic [8:0]        i_ram_addr,
    input  wire logic [15:0]       i_ram_wdata,
    output logic                   o_int_reset,
    output logic                   o_cpu_run,
    output logic [15:0]            o_pc_start,
    output logic [15:0]            o_nmi_vector,
    output logic [15:0]            o_hwi_vec_first,
    output logic [15:0]            o_hwi_vec_last,
    output logic                   o_irq_block,
    output logic                   o_int_flag,
    output logic                   o_ext_flag,
    output logic [9:0]             o_sp_wide,
    output logic [7:0]             o_sp_nib,
    output logic                   o_pins_default,
    output logic                   o_sleep_illegal,
    output logic [12:0]            o_rom_rdata,
    output logic [15:0]            o_ram_rdata,
    output logic                   o_ram_fault
);
    // ==========================================
    // Input synchronisers
    logic [5:0] sync1_reg;                 // First stage, read by stage two only
    logic [5:0] sync2_reg;                 // Second stage, safe to use
    logic       osc_prev_reg;              // For oscillator edge detect
    logic       pin_low;
    logic [3:0] keys;
    logic       osc_edge;
    always_ff @(posedge i_clk_sys) begin
        sync1_reg    <= {i_low_speed_osc, i_reset_pin_b, i_key_input_group};
        sync2_reg    <= sync1_reg;
        osc_prev_reg <= sync2_reg[5];
    end
    assign pin_low  = ~sync2_reg[4];
    assign keys     = sync2_reg[3:0];
    assign osc_edge = sync2_reg[5] & ~osc_prev_reg;

    // ==========================================
    // Oscillator divider to the 4 Hz tick
    logic [15:0] div_reg, div_next;        // Oscillator edge count
    logic        osc_run_reg, osc_run_next; // Oscillator seen running
    logic        tick;                     // 4 Hz pulse, one cycle
    // Divider keeps counting through reset: the release depends on it
    always_comb begin
        div_next     = div_reg;
        osc_run_next = osc_run_reg | osc_edge;
        tick         = 1'b0;
        if (osc_edge) begin
            if (div_reg == 16'(TICK_DIV - 1)) begin
                div_next = 16'h0000;
                tick     = 1'b1;
            end else begin
                div_next = div_reg + 16'h0001;
            end
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            div_reg     <= 16'h0000;
            osc_run_reg <= 1'b0;
        end else begin
            div_reg     <= div_next;
            osc_run_reg <= osc_run_next;
        end
    end

    // ==========================================
    // Key-combination qualifier
    irs_pkg::irs_kq_e kq_reg, kq_next;     // Qualifier state
    logic [15:0]      kcnt_reg, kcnt_next; // Filter edges or auth ticks
    logic             combo;               // Selected keys all low
    logic             key_fire;
    assign combo = i_cfg.key_en & (i_cfg.key_mask != 4'h0)
                 & ((keys & i_cfg.key_mask) == 4'h0);
    assign key_fire = (kq_reg == irs_pkg::KQ_FIRE);
    // Filter counts oscillator edges, so nothing qualifies before it runs
    always_comb begin
        kq_next   = kq_reg;
        kcnt_next = kcnt_reg;
        if (!combo) begin
            kq_next   = irs_pkg::KQ_IDLE;
            kcnt_next = 16'h0000;
        end else begin
            case (kq_reg)
                irs_pkg::KQ_IDLE: begin
                    kq_next   = irs_pkg::KQ_FILT;
                    kcnt_next = 16'h0000;
                end
                irs_pkg::KQ_FILT: begin
                    if (osc_run_reg && osc_edge) begin
                        kcnt_next = kcnt_reg + 16'h0001;
                        if (kcnt_reg == 16'(FILT_OSC - 1)) begin
                            kcnt_next = 16'h0000;
                            kq_next   = i_cfg.auth_en ? irs_pkg::KQ_AUTH
                                                      : irs_pkg::KQ_FIRE;
                        end
                    end
                end
                // five quarter-second ticks span 1 to 1.25 s
                irs_pkg::KQ_AUTH: begin
                    if (tick) begin
                        kcnt_next = kcnt_reg + 16'h0001;
                        if (kcnt_reg == 16'(`IRS_AUTH_TICKS - 1)) begin
                            kq_next = irs_pkg::KQ_FIRE;
                        end
                    end
                end
                // Holds while keys stay low
                irs_pkg::KQ_FIRE: kq_next = irs_pkg::KQ_FIRE;
                default:          kq_next = irs_pkg::KQ_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            kq_reg   <= irs_pkg::KQ_IDLE;
            kcnt_reg <= 16'h0000;
        end else begin
            kq_reg   <= kq_next;
            kcnt_reg <= kcnt_next;
        end
    end

    // ==========================================
    // Reset latch
    logic rst_latch_reg, rst_latch_next;   // Internal reset, set-reset latch
    always_comb begin
        rst_latch_next = rst_latch_reg;
        if (pin_low || key_fire) begin
            rst_latch_next = 1'b1;         // Set wins over any tick
        end else if (tick) begin
            rst_latch_next = 1'b0;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rst_latch_reg <= 1'b1;         // Power-on enters reset
        end else begin
            rst_latch_reg <= rst_latch_next;
        end
    end
    assign o_int_reset = rst_latch_reg;
    assign o_cpu_run   = ~rst_latch_reg;
    assign o_pins_default = rst_latch_reg;
    assign o_pc_start      = `IRS_PC_RESET;
    assign o_nmi_vector    = `IRS_NMI_VECTOR;
    assign o_hwi_vec_first = `IRS_HWI_VEC_FIRST;
    assign o_hwi_vec_last  = `IRS_HWI_VEC_LAST;

    // ==========================================
    // CPU flags, stack pointers, interrupt gate
    logic       spw_set_reg, spw_set_next; // Wide pointer written
    logic       spn_set_reg, spn_set_next; // Nibble pointer written
    logic       intf_reg, intf_next;
    logic       extf_reg, extf_next;
    logic [9:0] spw_reg, spw_next;
    logic [7:0] spn_reg, spn_next;
    logic       slp_reg, slp_next;
    always_comb begin
        spw_set_next = spw_set_reg;
        spn_set_next = spn_set_reg;
        intf_next    = intf_reg;
        extf_next    = extf_reg;
        spw_next     = spw_reg;
        spn_next     = spn_reg;
        slp_next     = i_sleep_decode;
        if (i_instr_done) begin
            extf_next = 1'b0;              // Prefix lasts one instruction
        end
        if (i_prefix_wr) begin
            extf_next = 1'b1;
        end
        if (i_int_flag_wr) begin
            intf_next = i_int_flag_data;
        end
        if (i_stack.call_push || i_stack.irq_push) begin
            spw_next = (spw_reg - `IRS_CALL_WORDS) & `IRS_SPW_MASK;
        end
        if (i_stack.irq_push) begin
            spn_next = (spn_reg - `IRS_FLAG_WORDS) & `IRS_SPN_MASK;
        end
        if (i_stack.wide_wr) begin
            spw_next     = i_stack.wide_data;
            spw_set_next = 1'b1;
            if (spw_set_reg && spn_set_reg && !i_stack.nib_wr) begin
                spn_set_next = 1'b0;
            end
        end
        if (i_stack.nib_wr) begin
            spn_next     = i_stack.nib_data;
            spn_set_next = 1'b1;
            if (spw_set_reg && spn_set_reg && !i_stack.wide_wr) begin
                spw_set_next = 1'b0;
            end
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b || rst_latch_reg) begin
            spw_set_reg <= 1'b0;
            spn_set_reg <= 1'b0;
            intf_reg    <= 1'b0;
            extf_reg    <= 1'b0;
            slp_reg     <= 1'b0;
        end else begin
            spw_set_reg <= spw_set_next;
            spn_set_reg <= spn_set_next;
            intf_reg    <= intf_next;
            extf_reg    <= extf_next;
            slp_reg     <= slp_next;
        end
    end
    // Pointers stay undefined across reset, so no reset term
    always_ff @(posedge i_clk_sys) begin
        spw_reg <= spw_next;
        spn_reg <= spn_next;
    end
    assign o_irq_block     = ~(spw_set_reg & spn_set_reg);
    assign o_int_flag      = intf_reg;
    assign o_ext_flag      = extf_reg;
    assign o_sp_wide       = spw_reg;
    assign o_sp_nib        = spn_reg;
    assign o_sleep_illegal = slp_reg;

    // ==========================================
    // Program and data memory
    // program store
    logic [`IRS_ROM_WIDTH-1:0] rom_mem [`IRS_ROM_DEPTH];
    logic [3:0]  ram_mem [`IRS_RAM_DEPTH];
    logic [12:0] rom_q_reg;
    logic [15:0] ram_q_reg;
    logic        ram_fault_reg;
    logic        wide_ok;
    logic [8:0]  a0, a1, a2, a3;
    assign wide_ok = i_ram_addr >= `IRS_RAM_WIDE_LO;
    assign a0 = i_ram_addr;
    assign a1 = i_ram_addr + 9'h001;
    assign a2 = i_ram_addr + 9'h002;
    assign a3 = i_ram_addr + 9'h003;
    // Wide write below 0100H is refused; any wide access there is flagged
    always_ff @(posedge i_clk_sys) begin
        if (i_rom_wr) begin
            rom_mem[i_rom_addr] <= i_rom_wdata;
        end
        rom_q_reg <= rom_mem[i_rom_addr];
        if (i_ram_wr && (!i_ram_wide || wide_ok)) begin
            ram_mem[a0] <= i_ram_wdata[3:0];
            if (i_ram_wide) begin
                ram_mem[a1] <= i_ram_wdata[7:4];
                ram_mem[a2] <= i_ram_wdata[11:8];
                ram_mem[a3] <= i_ram_wdata[15:12];
            end
        end
        if (!i_ram_wide) begin
            ram_q_reg <= {12'h000, ram_mem[a0]};
        end else begin
            ram_q_reg <= {ram_mem[a3], ram_mem[a2],
                          ram_mem[a1], ram_mem[a0]};
        end
        ram_fault_reg <= i_rst_b & i_ram_wide & ~wide_ok;
    end
    assign o_rom_rdata = rom_q_reg;
    assign o_ram_rdata = ram_q_reg;
    assign o_ram_fault = ram_fault_reg;

    // ==========================================
    // Checks
    sequence pin_seen_s;
        pin_low;
    endsequence
    sequence held_s;
        o_int_reset;
    endsequence
    pin_sets_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
        pin_seen_s |=> held_s) else $error("pin low did not set reset");
    tick_release_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        $fell(o_int_reset) |-> $past(tick)) else $error("release off tick");
    fire_sets_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        key_fire |=> o_int_reset) else $error("key fire missed");
    osc_gate_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        !osc_run_reg |-> kq_reg != irs_pkg::KQ_FIRE) else $error("early fire");
    combo_need_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        $rose(key_fire) |-> $past(combo)) else $error("fire without combo");
    auth_path_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        $rose(key_fire) && i_cfg.auth_en |-> $past(kq_reg) == irs_pkg::KQ_AUTH
        && $past(tick)) else $error("auth skipped");
    flags_clear_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        $past(o_int_reset) |-> !o_int_flag && !o_ext_flag)
        else $error("flags not cleared");
    irq_gate_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        $past(o_int_reset) |-> o_irq_block) else $error("irq not blocked");
    rearm_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b || o_int_reset)
        !o_irq_block && i_stack.wide_wr && !i_stack.nib_wr |=> o_irq_block)
        else $error("rewrite did not rearm");
    prefix_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b || o_int_reset)
        i_prefix_wr |=> o_ext_flag) else $error("prefix flag missing");
    push_a: assert property (@(posedge i_clk_sys)
        disable iff (!i_rst_b)
        i_stack.irq_push && !i_stack.wide_wr && !i_stack.nib_wr |=>
        o_sp_wide == $past(o_sp_wide) - 10'h004
        && o_sp_nib == $past(o_sp_nib) - 8'h01) else $error("push size");
endmodule

/* hdl/irs_consts.svh */
// Constants of the initial reset sequencer
`ifndef IRS_CONSTS_SVH
`define IRS_CONSTS_SVH
// ==========================================
// Low-speed oscillator timing
`define IRS_OSC_HZ        32768
`define IRS_TICK_HZ       2
`define IRS_TICK_DIV      (`IRS_OSC_HZ / `IRS_TICK_HZ / 2)
`define IRS_KEY_FILT_US   1500
`define IRS_KEY_FILT_OSC  ((`IRS_KEY_FILT_US * `IRS_OSC_HZ) / 1000000)
`define IRS_AUTH_TICKS    5
// ==========================================
// CPU reset values and memory layout
`define IRS_PC_RESET      16'h0110
`define IRS_NMI_VECTOR    16'h0100
`define IRS_HWI_VEC_FIRST 16'h0102
`define IRS_HWI_VEC_LAST  16'h010E
`define IRS_ROM_DEPTH     8192
`define IRS_ROM_WIDTH     13
`define IRS_RAM_DEPTH     512
`define IRS_RAM_WIDE_LO   9'h100
`define IRS_SPW_MASK      10'h3FF
`define IRS_SPN_MASK      8'hFF
`define IRS_CALL_WORDS    10'h004
`define IRS_FLAG_WORDS    8'h01
`endif

/* hdl/irs_pkg.sv */
// Types of the initial reset sequencer
package irs_pkg;
    // Key-combination qualifier states
    typedef enum logic [1:0] {
        KQ_IDLE,
        KQ_FILT,
        KQ_AUTH,
        KQ_FIRE
    } irs_kq_e;
    // Key reset options, fixed at build time in a real part
    typedef struct packed {
        logic       key_en;
        logic [3:0] key_mask;
        logic       auth_en;
    } irs_cfg_s;
    // Stack activity from the CPU
    typedef struct packed {
        logic       wide_wr;
        logic [9:0] wide_data;
        logic       nib_wr;
        logic [7:0] nib_data;
        logic       call_push;
        logic       irq_push;
    } irs_stack_s;
endpackage

/* verification/irs_ext_src.sv */
// External reset source, keypad and low-speed oscillator model
module irs_ext_src #(
    parameter int OSC_HALF_NS = 40,    // Scaled oscillator half period
    parameter int MIN_LOW_CYC = 25000, // Shortest pin pulse, 0.1 ms
    parameter int MIN_KEY_CYC = 100    // Scaled key hold, above filter
) (
    input  wire logic       i_clk,
    output logic            o_reset_pin_b,
    output logic [3:0]      o_key_input_group,
    output logic            o_low_speed_osc
);
    timeunit 1ns;
    timeprecision 1ps;

    logic osc_run;   // Oscillator stands still until started

    // Idle levels: pin released high, keys pulled up
    initial begin
        o_reset_pin_b     = 1'b1;
        o_key_input_group = 4'hF;
        o_low_speed_osc   = 1'b0;
        osc_run           = 1'b0;
    end

    // ==========================================
    // Oscillator
    // late oscillator start
    always begin
        wait (osc_run);
        #(OSC_HALF_NS) o_low_speed_osc = ~o_low_speed_osc;
    end

    task automatic start_osc();
        osc_run = 1'b1;
    endtask

    // ==========================================
    // Reset pin and keys
    // minimum pin low
    task automatic hold_reset(input int cyc);
        @(negedge i_clk);
        o_reset_pin_b = 1'b0;
        repeat ((cyc < MIN_LOW_CYC) ? MIN_LOW_CYC : cyc) @(negedge i_clk);
        o_reset_pin_b = 1'b1;
    endtask

    task automatic press_keys(input logic [3:0] pat, input int cyc);
        @(negedge i_clk);
        o_key_input_group = pat;
        repeat ((cyc < MIN_KEY_CYC) ? MIN_KEY_CYC : cyc) @(negedge i_clk);
        // Released keys go back to the pull-up level
        o_key_input_group = 4'hF;
    endtask
endmodule

/* verification/irs_top_bench.sv */
// Self-checking bench of the initial reset sequencer
module irs_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk       = 1'b0;
    logic                rst_b     = 1'b0;
    logic                pin_b;
    logic                osc;
    logic [3:0]          keys;
    irs_pkg::irs_cfg_s   cfg       = '0;
    irs_pkg::irs_stack_s stk       = '0;
    logic                pfx_wr    = 1'b0;
    logic                ins_done  = 1'b0;
    logic                iflag_wr  = 1'b0;
    logic                iflag_d   = 1'b0;
    logic                sleep_instruction       = 1'b0;
    logic                rom_wr    = 1'b0;
    logic [12:0]         rom_addr  = '0;
    logic [12:0]         rom_wdata = '0;
    logic                ram_wr    = 1'b0;
    logic                ram_wide  = 1'b0;
    logic [8:0]          ram_addr  = '0;
    logic [15:0]         ram_wdata = '0;
    logic                int_rst, run, irq_blk, iflag, eflag, pins, slp_bad;
    logic                fault;
    logic [15:0]         pc, nmi, hw_lo, hw_hi, ram_rd;
    logic [9:0]          sp_w;
    logic [7:0]          sp_n;
    logic [12:0]         rom_rd;
    int                  error_cnt = 0;
    int                  checked   = 0;

    // ==========================================
    // Clock and instances
    initial begin
        forever #2 clk = ~clk;
    end

    irs_ext_src SRC (.i_clk(clk), .o_reset_pin_b(pin_b),
        .o_key_input_group(keys), .o_low_speed_osc(osc));

    // Short tick and filter counts keep the run brief
    irs_top #(.TICK_DIV(4), .FILT_OSC(3)) DUT (.i_clk_sys(clk),
        .i_rst_b(rst_b), .i_reset_pin_b(pin_b), .i_low_speed_osc(osc),
        .i_key_input_group(keys), .i_cfg(cfg), .i_stack(stk),
        .i_prefix_wr(pfx_wr), .i_instr_done(ins_done),
        .i_int_flag_wr(iflag_wr), .i_int_flag_data(iflag_d),
        .i_sleep_decode(sleep_instruction), .i_rom_wr(rom_wr), .i_rom_addr(rom_addr),
        .i_rom_wdata(rom_wdata), .i_ram_wr(ram_wr), .i_ram_wide(ram_wide),
        .i_ram_addr(ram_addr), .i_ram_wdata(ram_wdata),
        .o_int_reset(int_rst), .o_cpu_run(run), .o_pc_start(pc),
        .o_nmi_vector(nmi), .o_hwi_vec_first(hw_lo),
        .o_hwi_vec_last(hw_hi), .o_irq_block(irq_blk),
        .o_int_flag(iflag), .o_ext_flag(eflag), .o_sp_wide(sp_w),
        .o_sp_nib(sp_n), .o_pins_default(pins), .o_sleep_illegal(slp_bad),
        .o_rom_rdata(rom_rd), .o_ram_rdata(ram_rd), .o_ram_fault(fault));

    // ==========================================
    // Compare and access tasks
    task automatic chk_val(input string nm, input logic [15:0] e,
                           input logic [15:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Bounded wait; arrival must fall in [lo, hi) cycles
    task automatic wait_rst(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (int_rst !== lvl && n < hi) begin
            cyc(1);
            n++;
        end
        chk_val("int_reset_time", 16'h0001, 16'(n >= lo && n < hi));
    endtask

    // One-cycle strobe; outputs of its edge are settled on return
    task automatic pulse(ref logic s);
        cyc(1);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask

    task automatic stk_op(input logic ww, input logic [9:0] wd,
        input logic nw, input logic [7:0] nd, input logic cp, input logic ip);
        cyc(1);
        stk = '{ww, wd, nw, nd, cp, ip};
        cyc(1);
        stk = '0;
    endtask

    task automatic rom_acc(input logic w, input logic [12:0] a,
                           input logic [12:0] d);
        cyc(1);
        rom_wr = w;
        rom_addr = a;
        rom_wdata = d;
        cyc(1);
        rom_wr = 1'b0;
    endtask

    task automatic ram_acc(input logic w, input logic wd,
                           input logic [8:0] a, input logic [15:0] d);
        cyc(1);
        ram_wr = w;
        ram_wide = wd;
        ram_addr = a;
        ram_wdata = d;
        cyc(1);
        ram_wr = 1'b0;
    endtask

    // Key press with the reset level looked at while still pressed
    task automatic key_case(input logic [3:0] m, input logic [3:0] pat,
                            input logic e);
        cfg = '{1'b1, m, 1'b0};
        fork
            SRC.press_keys(pat, 150);
            begin
                cyc(120);
                chk_val("key_reset", {15'h0, e}, {15'h0, int_rst});
            end
        join
        cfg.key_en = 1'b0;
        wait_rst(1'b0, 0, 200);
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well above the expected 27k cycles
    initial begin
        #(80000 * 4);
        error_cnt++;
        end_of_test();
    end

    // ==========================================
    // Test sequence
    initial begin
        cyc(10);
        chk_val("int_reset", 16'h0001, {15'h0, int_rst});
        chk_val("irq_block", 16'h0001, {15'h0, irq_blk});
        chk_val("flags", 16'h0000, {14'h0, iflag, eflag});
        chk_val("pins_default", 16'h0001, {15'h0, pins});
        chk_val("pc_start", 16'h0110, pc);
        chk_val("nmi_vector", 16'h0100, nmi);
        chk_val("hwi_first", 16'h0102, hw_lo);
        chk_val("hwi_last", 16'h010E, hw_hi);
        rst_b = 1'b1;
        cyc(200);
        chk_val("no_tick_hold", 16'h0001, {15'h0, int_rst});
        SRC.start_osc();
        wait_rst(1'b0, 0, 200);
        chk_val("run_pins", 16'h0002, {14'h0, run, pins});
        stk_op(1'b1, 10'h002, 1'b0, 8'h00, 1'b0, 1'b0);
        chk_val("block_one_sp", 16'h0001, {15'h0, irq_blk});
        stk_op(1'b0, 10'h000, 1'b1, 8'h00, 1'b0, 1'b0);
        chk_val("block_both_sp", 16'h0000, {15'h0, irq_blk});
        stk_op(1'b0, 10'h000, 1'b0, 8'h00, 1'b1, 1'b0);
        chk_val("sp_call", 16'h03FE, {6'h0, sp_w});
        stk_op(1'b0, 10'h000, 1'b0, 8'h00, 1'b0, 1'b1);
        chk_val("sp_irq", 16'hFAFF, {sp_w[7:0], sp_n});
        stk_op(1'b0, 10'h000, 1'b1, 8'h40, 1'b0, 1'b0);
        chk_val("block_rewrite", 16'h0001, {15'h0, irq_blk});
        stk_op(1'b1, 10'h100, 1'b0, 8'h00, 1'b0, 1'b0);
        chk_val("block_pair", 16'h0000, {15'h0, irq_blk});
        pulse(pfx_wr);
        chk_val("ext_set", 16'h0001, {15'h0, eflag});
        pulse(ins_done);
        chk_val("ext_clear", 16'h0000, {15'h0, eflag});
        iflag_d = 1'b1;
        pulse(iflag_wr);
        pulse(sleep_instruction);
        chk_val("sleep_flag", 16'h0001, {15'h0, slp_bad});
        cyc(1);
        chk_val("sleep_once", 16'h0000, {15'h0, slp_bad});
        rom_acc(1'b1, 13'h1FFF, 13'h1ABC);
        rom_acc(1'b1, 13'h0000, 13'h0055);
        rom_acc(1'b0, 13'h1FFF, 13'h0000);
        chk_val("rom_top", 16'h1ABC, {3'h0, rom_rd});
        ram_acc(1'b1, 1'b0, 9'h0FC, 16'h0007);
        ram_acc(1'b1, 1'b1, 9'h100, 16'h1234);
        ram_acc(1'b0, 1'b1, 9'h100, 16'h0000);
        chk_val("ram_wide", 16'h1234, ram_rd);
        ram_acc(1'b0, 1'b0, 9'h101, 16'h0000);
        chk_val("ram_nibble", 16'h0003, ram_rd);
        ram_acc(1'b1, 1'b1, 9'h0FC, 16'hFFFF);
        chk_val("ram_fault", 16'h0001, {15'h0, fault});
        ram_acc(1'b0, 1'b0, 9'h0FC, 16'h0000);
        chk_val("ram_refused", 16'h0007, ram_rd);
        fork
            SRC.hold_reset(0);
            begin
                wait_rst(1'b1, 0, 6);
                cyc(1);
                chk_val("reset_flags", 16'h0001,
                        {13'h0, iflag, eflag, irq_blk});
            end
        join
        chk_val("latch_holds", 16'h0001, {15'h0, int_rst});
        wait_rst(1'b0, 0, 200);
        chk_val("block_after", 16'h0001, {15'h0, irq_blk});
        key_case(4'hF, 4'h0, 1'b1);
        key_case(4'hF, 4'h1, 1'b0);
        key_case(4'h3, 4'h4, 1'b1);
        key_case(4'h3, 4'hE, 1'b0);
        cfg = '{1'b1, 4'hF, 1'b1};
        fork
            SRC.press_keys(4'h0, 150);
            begin
                cyc(140);
                chk_val("auth_short", 16'h0000, {15'h0, int_rst});
            end
        join
        cyc(10);
        fork
            SRC.press_keys(4'h0, 700);
            begin
                cyc(180);
                chk_val("auth_early", 16'h0000, {15'h0, int_rst});
                wait_rst(1'b1, 0, 400);
            end
        join
        wait_rst(1'b0, 0, 200);
        end_of_test();
    end
endmodule
